// ### oag_consts.svh
// Purpose: Constants for the operand address generator
// Assumes: 24-bit pointers, 32-bit instruction words
// Notes:   Mode codes are the 5-bit modification field values
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH
`define OAG_PTR_W        24
`define OAG_INSN_W       32
`define OAG_DISP_W       8
`define OAG_DISP_IMPLIED 8'h01
`define OAG_SHORT_W      16
`define OAG_LONG_W       24
`define OAG_BK_W         16
`define OAG_PC_INC       24'h000001
`define OAG_BRTYPE_BIT   24
`define OAG_M_PRE_ADD_D  5'h00
`define OAG_M_PRE_SUB_D  5'h01
`define OAG_M_PRE_ADDM_D 5'h02
`define OAG_M_PRE_SUBM_D 5'h03
`define OAG_M_PST_ADD_D  5'h04
`define OAG_M_PST_SUB_D  5'h05
`define OAG_M_PST_CADD_D 5'h06
`define OAG_M_PST_CSUB_D 5'h07
`define OAG_M_PLAIN      5'h18
`define OAG_M_BITREV     5'h19
`endif

// ### oag_pkg.sv
// Purpose: Types for the operand address generator
// Assumes: oag_consts.svh constants
// Notes:   Request and answer travel as packed structs
`include "oag_consts.svh"
package oag_pkg;
   typedef enum logic [3:0]
   {
      OAG_IDLE   = 4'h1,
      OAG_ADDR   = 4'h2,
      OAG_BRANCH = 4'h4,
      OAG_IMM    = 4'h8
   } oag_state_t;

   typedef struct packed
   {
      logic [4:0]                 mode;
      logic                       disp_given;
      logic [`OAG_DISP_W-1:0]     disp;
      logic [`OAG_PTR_W-1:0]      aux_pointer_n;
      logic [`OAG_PTR_W-1:0]      index_reg_zero;
      logic [`OAG_PTR_W-1:0]      index_reg_one;
      logic [`OAG_BK_W-1:0]       block_size_reg;
   } oag_ind_req_t;

   typedef struct packed
   {
      logic [`OAG_PTR_W-1:0]      addr;
      logic [`OAG_PTR_W-1:0]      new_ptr;
      logic                       ptr_we;
   } oag_ind_rsp_t;

   typedef struct packed
   {
      oag_state_t                 state;
      oag_ind_rsp_t               ind;
      logic                       ind_valid;
      logic [`OAG_PTR_W-1:0]      target;
      logic                       delayed;
      logic                       br_valid;
      logic [`OAG_INSN_W-1:0]     imm;
      logic                       imm_valid;
   } oag_regs_t;
endpackage : oag_pkg

// ### oag_core.sv
// Purpose: Operand address, immediate and branch target generation
// Assumes: Decode supplies at most one request of each kind per cycle, same clock
// Notes:   All outputs registered, one cycle after the request
// Function
// - Displacement is 8-bit unsigned from the instruction, else implied 1.
// - Post-displacement subtract: address pointer, then write pointer minus displacement.
// - Mode 00110: address pointer, then write circular pointer plus displacement.
// - Post-displacement circular subtract: address pointer, write circular difference.
// - Modes 01000/10000: address pointer plus index, pointer unchanged.
// - Modes 01001/10001: address pointer minus index, pointer unchanged.
// - Modes 01010/10010: address pointer plus index, write it back.
// - Modes 01011/10011: address pointer minus index, write it back.
// - Modes 01100/10100: address pointer, then add index to pointer.
// - Modes 01101/10101: address pointer, then subtract index from pointer.
// - Modes 01110/10110: address pointer, then circular pointer plus index.
// - Modes 01111/10111: address pointer, then circular pointer minus index.
// - Bit-reversed mode: address pointer, reverse-carry add first index register.
// - Short immediate is low 16 instruction bits, sign-extended if imm_signed, else zero-extended.
// - Long immediate is low 24 instruction bits, unsigned.
// - Relative branch adds signed 16 or 24-bit displacement to PC.
// - PC already incremented by one, displacement adds to that.
// - Bit 24 selects standard (0) or delayed (1) long branch; short branch is always standard.
// - Circular wrap on low bits: keep, minus block size, or plus.
`timescale 1ns/100ps
`include "oag_consts.svh"
module oag_core
   import oag_pkg::*;
(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // Indirect address request
   input  wire logic                   ind_req,
   input  wire oag_ind_req_t           ind_in,
   // Immediate request
   input  wire logic                   imm_req,
   input  wire logic                   imm_long,
   input  wire logic                   imm_signed,
   // Branch request
   input  wire logic                   br_req,
   input  wire logic                   br_long,
   input  wire logic [`OAG_PTR_W-1:0]  pc_fetch,
   // Instruction word
   input  wire logic [`OAG_INSN_W-1:0] insn,
   // Indirect answer
   output logic                        ind_valid,
   output oag_ind_rsp_t                ind_out,
   // Immediate answer
   output logic                        imm_valid,
   output logic [`OAG_INSN_W-1:0]      imm_value,
   // Branch answer
   output logic                        br_valid,
   output logic [`OAG_PTR_W-1:0]       br_target,
   output logic                        br_delayed
);

   oag_regs_t r;
   oag_regs_t next_r;

   // Wrap a stepped pointer inside the circular block; low 16 bits only
   function automatic logic [`OAG_PTR_W-1:0] circ_step(
      input logic [`OAG_PTR_W-1:0] ptr,
      input logic [`OAG_PTR_W-1:0] step,
      input logic                  sub,
      input logic [`OAG_BK_W-1:0]  bk);
      logic [`OAG_BK_W-1:0]   mask;
      logic [`OAG_BK_W-1:0]   idx;
      logic signed [`OAG_BK_W+9:0] sum;
      logic [`OAG_BK_W-1:0]   res;
      integer                 i;
      mask = '0;
      // Index field is the bits below the alignment boundary 2^K > bk
      for (i = 0; i < `OAG_BK_W; i++)
      begin
         if (bk > ((`OAG_BK_W'(1) << i) - `OAG_BK_W'(1)) && bk != '0)
            mask[i] = 1'b1;
      end
      idx = ptr[`OAG_BK_W-1:0] & mask;
      if (sub)
         sum = $signed({10'h000, idx}) - $signed({10'h000, step[`OAG_BK_W-1:0]});
      else
         sum = $signed({10'h000, idx}) + $signed({10'h000, step[`OAG_BK_W-1:0]});
      if (sum < 0)
         sum = sum + $signed({10'h000, bk});
      else if (sum >= $signed({10'h000, bk}))
         sum = sum - $signed({10'h000, bk});
      res = (ptr[`OAG_BK_W-1:0] & ~mask) | (sum[`OAG_BK_W-1:0] & mask);
      return {ptr[`OAG_PTR_W-1:`OAG_BK_W], res};
   endfunction : circ_step

   // Reverse bit order over pointer width
   function automatic logic [`OAG_PTR_W-1:0] rev(input logic [`OAG_PTR_W-1:0] v);
      logic [`OAG_PTR_W-1:0] o;
      integer                i;
      o = '0;
      for (i = 0; i < `OAG_PTR_W; i++)
         o[i] = v[`OAG_PTR_W-1-i];
      return o;
   endfunction : rev

   // Address and writeback for every modification field
   always_comb
   begin
      logic [`OAG_PTR_W-1:0] disp;
      logic [`OAG_PTR_W-1:0] idx;
      logic [`OAG_PTR_W-1:0] ptr;
      logic [`OAG_PTR_W-1:0] step;
      logic                  use_idx;
      disp    = '0;
      idx     = '0;
      ptr     = ind_in.aux_pointer_n;
      step    = '0;
      use_idx = 1'b0;
      next_r  = r;
      next_r.state     = OAG_IDLE;
      next_r.ind_valid = 1'b0;
      next_r.br_valid  = 1'b0;
      next_r.imm_valid = 1'b0;
      // Missing displacement means an implied step of one
      disp = ind_in.disp_given ? {16'h0000, ind_in.disp}
                               : {16'h0000, `OAG_DISP_IMPLIED};
      idx  = ind_in.mode[4] ? ind_in.index_reg_one : ind_in.index_reg_zero;
      use_idx = ind_in.mode[4] ^ ind_in.mode[3];
      step = use_idx ? idx : disp;
      if (ind_req)
      begin
         next_r.state      = OAG_ADDR;
         next_r.ind_valid  = 1'b1;
         next_r.ind.addr   = ptr;
         next_r.ind.new_ptr = ptr;
         next_r.ind.ptr_we = 1'b0;
         if (ind_in.mode == `OAG_M_PLAIN)
            next_r.ind.ptr_we = 1'b0;
         else if (ind_in.mode == `OAG_M_BITREV)
         begin
            next_r.ind.new_ptr = rev(rev(ptr) + rev(ind_in.index_reg_zero));
            next_r.ind.ptr_we  = 1'b1;
         end
         else if (ind_in.mode[4:3] != 2'b11)
         begin
            // Low three bits pick the operation, same for disp and index
            case (ind_in.mode[2:0])
               3'h0: next_r.ind.addr = ptr + step;
               3'h1: next_r.ind.addr = ptr - step;
               3'h2:
               begin
                  next_r.ind.addr    = ptr + step;
                  next_r.ind.new_ptr = ptr + step;
                  next_r.ind.ptr_we  = 1'b1;
               end
               3'h3:
               begin
                  next_r.ind.addr    = ptr - step;
                  next_r.ind.new_ptr = ptr - step;
                  next_r.ind.ptr_we  = 1'b1;
               end
               3'h4:
               begin
                  next_r.ind.new_ptr = ptr + step;
                  next_r.ind.ptr_we  = 1'b1;
               end
               3'h5:
               begin
                  next_r.ind.new_ptr = ptr - step;
                  next_r.ind.ptr_we  = 1'b1;
               end
               3'h6:
               begin
                  next_r.ind.new_ptr = circ_step(ptr, step, 1'b0, ind_in.block_size_reg);
                  next_r.ind.ptr_we  = 1'b1;
               end
               3'h7:
               begin
                  next_r.ind.new_ptr = circ_step(ptr, step, 1'b1, ind_in.block_size_reg);
                  next_r.ind.ptr_we  = 1'b1;
               end
               default: next_r.ind.ptr_we = 1'b0;
            endcase
         end
      end
      // Immediate extraction
      if (imm_req)
      begin
         next_r.imm_valid = 1'b1;
         if (imm_long)
            next_r.imm = {8'h00, insn[`OAG_LONG_W-1:0]};
         else if (imm_signed)
            next_r.imm = {{16{insn[`OAG_SHORT_W-1]}}, insn[`OAG_SHORT_W-1:0]};
         else
            next_r.imm = {16'h0000, insn[`OAG_SHORT_W-1:0]};
      end
      // Branch target: pc_fetch is already the incremented PC
      if (br_req)
      begin
         next_r.br_valid = 1'b1;
         if (br_long)
         begin
            next_r.target  = pc_fetch + insn[`OAG_LONG_W-1:0];
            next_r.delayed = insn[`OAG_BRTYPE_BIT];
         end
         else
         begin
            next_r.target  = pc_fetch + {{8{insn[`OAG_SHORT_W-1]}}, insn[`OAG_SHORT_W-1:0]};
            next_r.delayed = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         r       <= '0;
         r.state <= OAG_IDLE;
      end
      else
         r <= next_r;
   end

   assign ind_valid  = r.ind_valid;
   assign ind_out    = r.ind;
   assign imm_valid  = r.imm_valid;
   assign imm_value  = r.imm;
   assign br_valid   = r.br_valid;
   assign br_target  = r.target;
   assign br_delayed = r.delayed;

   // Checks
   property p_implied_disp;
      @(posedge core_clk) disable iff (!rst_n)
      ind_req && !ind_in.disp_given && ind_in.mode == `OAG_M_PRE_ADD_D
      |=> ind_out.addr == $past(ind_in.aux_pointer_n) + 24'h000001;
   endproperty
   a_implied_disp: assert property (p_implied_disp) else $error("implied disp wrong");

   property p_post_sub;
      @(posedge core_clk) disable iff (!rst_n)
      ind_req && ind_in.mode == `OAG_M_PST_SUB_D
      |=> ind_out.addr == $past(ind_in.aux_pointer_n) && ind_out.ptr_we;
   endproperty
   a_post_sub: assert property (p_post_sub) else $error("post sub addr wrong");

   property p_circ_addr;
      @(posedge core_clk) disable iff (!rst_n)
      ind_req && ind_in.mode[2:1] == 2'b11 && ind_in.mode[4:3] != 2'b11
      |=> ind_out.addr == $past(ind_in.aux_pointer_n);
   endproperty
   a_circ_addr: assert property (p_circ_addr) else $error("circ addr wrong");

   property p_pre_add;
      @(posedge core_clk) disable iff (!rst_n)
      ind_req && ind_in.mode == 5'h10
      |=> ind_out.addr == $past(ind_in.aux_pointer_n) + $past(ind_in.index_reg_one) && !ind_out.ptr_we;
   endproperty
   a_pre_add: assert property (p_pre_add) else $error("pre add wrong");

   property p_pre_subm;
      @(posedge core_clk) disable iff (!rst_n)
      ind_req && ind_in.mode == 5'h0b
      |=> ind_out.addr == $past(ind_in.aux_pointer_n) - $past(ind_in.index_reg_zero)
          && ind_out.new_ptr == ind_out.addr && ind_out.ptr_we;
   endproperty
   a_pre_subm: assert property (p_pre_subm) else $error("pre sub modify wrong");

   property p_long_imm;
      @(posedge core_clk) disable iff (!rst_n)
      imm_req && imm_long |=> imm_valid && imm_value == {8'h00, $past(insn[23:0])};
   endproperty
   a_long_imm: assert property (p_long_imm) else $error("long imm wrong");

   property p_br_type;
      @(posedge core_clk) disable iff (!rst_n)
      br_req && br_long |=> br_valid && br_delayed == $past(insn[24]);
   endproperty
   a_br_type: assert property (p_br_type) else $error("branch type wrong");

   property p_br_target;
      @(posedge core_clk) disable iff (!rst_n)
      br_req && br_long |=> br_target == $past(pc_fetch) + $past(insn[23:0]);
   endproperty
   a_br_target: assert property (p_br_target) else $error("branch target wrong");

   // Request halves of the two-step checks; the answer lands one edge later
   sequence s_bitrev_req;
      ind_req && ind_in.mode == `OAG_M_BITREV;
   endsequence

   sequence s_post_ir1_req;
      ind_req && ind_in.mode == 5'h14;
   endsequence

   property p_bitrev_addr;
      @(posedge core_clk) disable iff (!rst_n)
      s_bitrev_req |=> ind_valid && ind_out.addr == $past(ind_in.aux_pointer_n) && ind_out.ptr_we;
   endproperty
   a_bitrev_addr: assert property (p_bitrev_addr) else $error("bit reversed addr wrong");

   property p_post_ir1;
      @(posedge core_clk) disable iff (!rst_n)
      s_post_ir1_req |=> ind_out.addr == $past(ind_in.aux_pointer_n)
         && ind_out.new_ptr == $past(ind_in.aux_pointer_n) + $past(ind_in.index_reg_one);
   endproperty
   a_post_ir1: assert property (p_post_ir1) else $error("post index add wrong");

   property p_short_imm;
      @(posedge core_clk) disable iff (!rst_n)
      imm_req && !imm_long && imm_signed
      |=> imm_value == {{16{$past(insn[15])}}, $past(insn[15:0])};
   endproperty
   a_short_imm: assert property (p_short_imm) else $error("short imm wrong");

   property p_short_br;
      @(posedge core_clk) disable iff (!rst_n)
      br_req && !br_long
      |=> br_valid && !br_delayed
          && br_target == $past(pc_fetch) + {{8{$past(insn[15])}}, $past(insn[15:0])};
   endproperty
   a_short_br: assert property (p_short_br) else $error("short branch wrong");
endmodule : oag_core

// ### oag_decode_model.sv
// Purpose: Decode stage model that feeds the operand address generator
// Assumes: Requests change 10 ns after the rising edge and hold a full cycle
// Notes:   Fields carry whatever the caller passes, whether or not their request is high
`timescale 1ns/100ps
`include "oag_consts.svh"
module oag_decode_model
   import oag_pkg::*;
(
   // Clock
   input  wire logic                   core_clk,
   // Requests toward the generator
   output logic                        ind_req,
   output oag_ind_req_t                ind_in,
   output logic                        imm_req,
   output logic                        imm_long,
   output logic                        imm_signed,
   output logic                        br_req,
   output logic                        br_long,
   output logic [`OAG_PTR_W-1:0]       pc_fetch,
   output logic [`OAG_INSN_W-1:0]      insn
);
   // Quiet start, so nothing is taken while reset settles
   initial
   begin
      {ind_req, imm_req, br_req} = 3'h0;
      {imm_long, imm_signed, br_long} = 3'h0;
      ind_in = '0;
      pc_fetch = '0;
      insn = '0;
   end

   // One request slot per cycle; all fields move together after the edge
   task automatic issue(input logic [2:0] req, input logic [2:0] fl, input oag_ind_req_t r,
                        input logic [23:0] pc, input logic [31:0] w);
      @(posedge core_clk);
      #10;
      {ind_req, imm_req, br_req} = req;
      {imm_long, imm_signed, br_long} = fl;
      ind_in = r;
      pc_fetch = pc;
      insn = w;
   endtask : issue
endmodule : oag_decode_model

// ### test_oag_core.sv
// Purpose: Self-checking bench for the operand address generator
// Assumes: Answers registered at the taking edge, checked at the falling edge after it
// Notes:   Expected results queued at issue, popped by the monitor
`timescale 1ns/100ps
`include "oag_consts.svh"
module test_oag_core;
   import oag_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst_n, ind_req, imm_req, imm_long, imm_signed, br_req, br_long;
   logic         ind_valid, imm_valid, br_valid, br_delayed;
   oag_ind_req_t ind_in;
   oag_ind_rsp_t ind_out, ei;
   logic [23:0]  pc_fetch, br_target;
   logic [31:0]  insn, imm_value, seed_ret;
   logic [2:0]   took = 3'h0;
   oag_ind_rsp_t q_ind[$];
   logic [31:0]  q_imm[$];
   logic [24:0]  q_br[$];
   int           fail_count = 0;
   int           checks_done = 0;

   // Clock, 100 ns period; low from declaration, so no false edge at time zero
   initial
   begin
      forever #50 core_clk = ~core_clk;
   end

   oag_core dut (.core_clk(core_clk), .rst_n(rst_n), .ind_req(ind_req), .ind_in(ind_in), .imm_req(imm_req),
      .imm_long(imm_long), .imm_signed(imm_signed), .br_req(br_req), .br_long(br_long), .pc_fetch(pc_fetch),
      .insn(insn), .ind_valid(ind_valid), .ind_out(ind_out), .imm_valid(imm_valid), .imm_value(imm_value),
      .br_valid(br_valid), .br_target(br_target), .br_delayed(br_delayed));
   oag_decode_model dec (.core_clk(core_clk), .ind_req(ind_req), .ind_in(ind_in), .imm_req(imm_req),
      .imm_long(imm_long), .imm_signed(imm_signed), .br_req(br_req), .br_long(br_long),
      .pc_fetch(pc_fetch), .insn(insn));

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // Wrap on the low K bits, K the smallest with 2^K above the block size
   function automatic logic [23:0] circ(input logic [23:0] p, s, input logic sub, input logic [15:0] bk);
      int k, n;
      logic [23:0] m;
      k = 0;
      while ((32'h1 << k) <= {16'h0, bk}) k++;
      m = (24'h1 << k) - 24'h1;
      n = sub ? int'(p & m) - int'(s) : int'(p & m) + int'(s);
      if (n >= int'(bk)) n -= int'(bk);
      else if (n < 0) n += int'(bk);
      return (p & ~m) | (24'(n) & m);
   endfunction : circ

   function automatic logic [23:0] rev(input logic [23:0] v);
      for (int i = 0; i < 24; i++) rev[i] = v[23-i];
   endfunction : rev

   // Low three mode bits share one meaning for displacement and index steps
   function automatic oag_ind_rsp_t ind_exp(input oag_ind_req_t r);
      logic [23:0] st, sum;
      oag_ind_rsp_t e;
      st = r.mode[4] ? r.index_reg_one : r.mode[3] ? r.index_reg_zero : r.disp_given ? {16'h0, r.disp} : 24'h1;
      sum = r.mode[0] ? r.aux_pointer_n - st : r.aux_pointer_n + st;
      e = '{r.aux_pointer_n, r.aux_pointer_n, 1'b0};
      if (r.mode == 5'h19) e = '{r.aux_pointer_n, rev(rev(r.aux_pointer_n) + rev(r.index_reg_zero)), 1'b1};
      else if (r.mode < 5'h18)
         case (r.mode[2:1])
            2'h0: e.addr = sum;
            2'h1: e = '{sum, sum, 1'b1};
            2'h2: e = '{r.aux_pointer_n, sum, 1'b1};
            default: e = '{r.aux_pointer_n, circ(r.aux_pointer_n, st, r.mode[0], r.block_size_reg), 1'b1};
         endcase
      return e;
   endfunction : ind_exp

   task automatic send(input logic [2:0] req, input logic [2:0] fl, input oag_ind_req_t r,
                       input logic [23:0] pc, input logic [31:0] w);
      if (req[2]) q_ind.push_back(ind_exp(r));
      if (req[1]) q_imm.push_back(fl[2] ? {8'h0, w[23:0]} : fl[1] ? {{16{w[15]}}, w[15:0]} : {16'h0, w[15:0]});
      if (req[0]) q_br.push_back(fl[0] ? {w[24], pc + w[23:0]} : {1'b0, pc + {{8{w[15]}}, w[15:0]}});
      dec.issue(req, fl, r, pc, w);
   endtask : send

   // Hand-worked case: the expected answer is written out, not derived
   task automatic known(input logic [4:0] m, input logic g, input logic [23:0] p, s,
                        input logic [15:0] bk, input oag_ind_rsp_t e);
      oag_ind_req_t r;
      r = '{m, g, s[7:0], p, s, s, bk};
      q_ind.push_back(e);
      dec.issue(3'h4, 3'h0, r, 24'h0, 32'h0);
   endtask : known

   // Random fields; circular steps kept within the block, pointer inside it
   task automatic go(input logic [2:0] req, input logic [4:0] mode);
      oag_ind_req_t r;
      r.mode = mode;
      r.disp_given = 1'($urandom);
      r.block_size_reg = 16'($urandom_range(1, 1023));
      r.index_reg_zero = 24'($urandom_range(0, r.block_size_reg));
      r.index_reg_one = 24'($urandom_range(0, r.block_size_reg));
      r.disp = 8'($urandom_range(0, r.block_size_reg < 255 ? r.block_size_reg : 255));
      r.aux_pointer_n = {14'($urandom), 10'h0} | 24'($urandom_range(0, r.block_size_reg - 1));
      if (mode[2:1] != 2'h3)
         {r.index_reg_zero, r.index_reg_one, r.disp} = {24'($urandom), 24'($urandom), 8'($urandom)};
      send(req, 3'($urandom), r, 24'($urandom), $urandom);
   endtask : go

   // Valid must follow exactly the requests taken at the previous edge
   always @(posedge core_clk)
      took <= {ind_req, imm_req, br_req} & {3{rst_n}};
   always @(negedge core_clk)
   begin
      chk("valids", {29'h0, ind_valid, imm_valid, br_valid}, {29'h0, took});
      if (took[2] && q_ind.size() > 0)
      begin
         ei = q_ind.pop_front();
         chk("ind_addr", {8'h0, ind_out.addr}, {8'h0, ei.addr});
         chk("ptr_we", {31'h0, ind_out.ptr_we}, {31'h0, ei.ptr_we});
         if (ei.ptr_we) chk("new_ptr", {8'h0, ind_out.new_ptr}, {8'h0, ei.new_ptr});
      end
      if (took[1] && q_imm.size() > 0) chk("imm_value", imm_value, q_imm.pop_front());
      if (took[0] && q_br.size() > 0) chk("branch", {7'h0, br_delayed, br_target}, {7'h0, q_br.pop_front()});
   end

   // Hang guard, far beyond the few hundred cycles of traffic
   initial
   begin
      #(3000 * 100);
      fail_count++;
      complete_run();
   end

   initial
   begin
      oag_ind_req_t w0;
      rst_n = 1'b0;
      seed_ret = $urandom(32'he6944e19);
      repeat (6) @(posedge core_clk);
      #10 rst_n = 1'b1;
      // Hand-over walk: post-index add, pointer 10, step 3
      w0 = '0;
      w0.mode = 5'h0c;
      w0.aux_pointer_n = 24'h00000a;
      w0.index_reg_zero = 24'h000003;
      send(3'h4, 3'h0, w0, 24'h0, 32'h0);
      // Wrap walk on a six-entry block, then reverse carry, implied steps, index pairs
      known(5'h06, 1'b1, 24'h123450, 24'h000005, 16'h0006, {24'h123450, 24'h123455, 1'b1});
      known(5'h06, 1'b1, 24'h123455, 24'h000002, 16'h0006, {24'h123455, 24'h123451, 1'b1});
      known(5'h07, 1'b1, 24'h123451, 24'h000003, 16'h0006, {24'h123451, 24'h123454, 1'b1});
      known(5'h0e, 1'b1, 24'h123454, 24'h000006, 16'h0006, {24'h123454, 24'h123454, 1'b1});
      known(5'h17, 1'b1, 24'h123454, 24'h000005, 16'h0006, {24'h123454, 24'h123455, 1'b1});
      known(5'h19, 1'b0, 24'h000004, 24'h000004, 16'h0000, {24'h000004, 24'h000002, 1'b1});
      known(5'h19, 1'b0, 24'h000006, 24'h000004, 16'h0000, {24'h000006, 24'h000001, 1'b1});
      known(5'h00, 1'b0, 24'h000100, 24'h000040, 16'h0000, {24'h000101, 24'h000100, 1'b0});
      known(5'h05, 1'b0, 24'h000100, 24'h000040, 16'h0000, {24'h000100, 24'h0000ff, 1'b1});
      known(5'h12, 1'b1, 24'h000010, 24'h000020, 16'h0000, {24'h000030, 24'h000030, 1'b1});
      known(5'h0b, 1'b1, 24'h000010, 24'h000020, 16'h0000, {24'hfffff0, 24'hfffff0, 1'b1});
      // Every mode four times, back to back with other requests
      for (int i = 0; i < 128; i++) go({1'b1, 2'($urandom)}, 5'(i));
      for (int i = 0; i < 24; i++) go(3'($urandom), 5'($urandom));
      // Standard branch encoded from target and incremented PC
      send(3'h1, 3'h1, w0, 24'h001001, {8'h0, 24'h000f80 - 24'h001001});
      // Requests during a mid-run reset are never taken
      @(posedge core_clk);
      #10 rst_n = 1'b0;
      dec.issue(3'h7, 3'h5, w0, 24'h000100, $urandom);
      dec.issue(3'h7, 3'h2, w0, 24'h000200, $urandom);
      send(3'h0, 3'h0, w0, 24'h0, 32'h0);
      @(posedge core_clk);
      #10 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) go(3'h7, 5'(i * 3));
      repeat (3) go(3'h0, 5'h0);
      chk("pending", 32'(q_ind.size() + q_imm.size() + q_br.size()), 32'h0);
      complete_run();
   end
endmodule : test_oag_core
